// ===== sotp_ctrl.sv
`timescale 1ns/100ps

// Function
// RULE_01: Opcode B1h enters the OTP mode
// RULE_02: Opcode C1h leaves the OTP mode
// RULE_03: OTP region is separate 4K-bit store
// RULE_04: In OTP mode read/program target region
// RULE_05: Locked region refuses every update
// RULE_06: Status/security writes ignored in OTP mode
// RULE_07: Locked OTP mode accepts read commands only; code also accepts enter (B1h) and exit (C1h)
// RULE_08: Enter/exit accepted in SPI and QPI
// RULE_09: OTP mode blocks all main-array writes
// RULE_10: Factory or customer lock, never cleared; code reloads custLock from custLockStored at reset
// RULE_11: Security write needs no write enable
// RULE_12: Reset starts outside OTP mode
module sotp_ctrl
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic serialClk,
	input wire logic chipSelN,
	input wire logic [3:0] ioIn,
	input wire logic qpiMode,
	input wire logic factoryLock,
	input wire logic custLockStored,
	output logic [3:0] ioOut,
	output logic [3:0] ioOe,
	output logic otpMode,
	output logic mainWriteBlock,
	output logic customerLock,
	output logic cmdStrobe,
	output logic [7:0] cmdOpcode,
	output logic cmdToOtp,
	output logic cmdRejected
);

	typedef struct packed {
		logic sck1;
		logic sck2;
		logic sckD;
		logic cs1;
		logic cs2;
		logic csD;
		logic [3:0] io1;
		logic [3:0] io2;
		sotp_pkg::sotp_phase_t phase;
		logic [2:0] cnt;
		logic [7:0] shift;
		logic [7:0] opcode;
		logic [23:0] addr;
		logic [1:0] addrBytes;
		logic execOk;
		logic otpMode;
		logic factLock;
		logic custLock;
		logic strapDone;
		logic [7:0] outShift;
		logic load;
		logic fresh;
		logic memWe;
		logic [sotp_pkg::OTP_ADDR_W-1:0] memAddr;
		logic [7:0] memData;
		logic cmdStrobe;
		logic [7:0] cmdOpcode;
		logic cmdToOtp;
		logic cmdRejected;
	} sotp_state_t;

	sotp_state_t st;
	sotp_state_t next_st;
	logic [7:0] rdData;

	////////////////////////////////////////////////////////////////////////
	// Opcode classes used by the admission check
	function automatic logic sotp_is_read(input logic [7:0] op);
		sotp_is_read = (op == sotp_pkg::OP_READ_DATA) || (op == sotp_pkg::OP_FAST_READ)
			|| (op == sotp_pkg::OP_DUAL_READ) || (op == sotp_pkg::OP_QUAD_READ)
			|| (op == sotp_pkg::OP_QUAD_IO_READ) || (op == sotp_pkg::OP_READ_STATUS1)
			|| (op == sotp_pkg::OP_READ_STATUS2) || (op == sotp_pkg::OP_READ_SECURITY);
	endfunction : sotp_is_read

	function automatic logic sotp_is_reg_write(input logic [7:0] op);
		sotp_is_reg_write = (op == sotp_pkg::OP_WRITE_STATUS1)
			|| (op == sotp_pkg::OP_WRITE_STATUS2) || (op == sotp_pkg::OP_WRITE_SECURITY);
	endfunction : sotp_is_reg_write

	////////////////////////////////////////////////////////////////////////
	// Region storage
	sotp_array uArray
	(
		.mclk(mclk),
		.writeEn(st.memWe),
		.writeAddr(st.memAddr),
		.writeData(st.memData),
		.readAddr(st.addr[sotp_pkg::OTP_ADDR_W-1:0]),
		.readData(rdData)
	);

	////////////////////////////////////////////////////////////////////////
	// Next-state logic; the serial clock is oversampled, so it must stay
	// well below a quarter of mclk
	always_comb
	begin
		logic sckRise;
		logic sckFall;
		logic csRise;
		logic csFall;
		logic locked;
		logic byteDone;
		logic [2:0] step;
		logic [3:0] cntSum;
		logic [7:0] inByte;
		sckRise = 1'b0;
		sckFall = 1'b0;
		csRise = 1'b0;
		csFall = 1'b0;
		locked = 1'b0;
		byteDone = 1'b0;
		step = sotp_pkg::STEP_SPI;
		cntSum = 4'h0;
		inByte = 8'h00;
		next_st = st;
		next_st.cmdStrobe = 1'b0;
		next_st.cmdRejected = 1'b0;
		next_st.memWe = 1'b0;
		next_st.load = 1'b0;
		// Two-stage synchronisers, third stage only for edge finding
		next_st.sck1 = serialClk;
		next_st.sck2 = st.sck1;
		next_st.sckD = st.sck2;
		next_st.cs1 = chipSelN;
		next_st.cs2 = st.cs1;
		next_st.csD = st.cs2;
		next_st.io1 = ioIn;
		next_st.io2 = st.io1;
		sckRise = st.sck2 && !st.sckD;
		sckFall = !st.sck2 && st.sckD;
		csRise = st.cs2 && !st.csD;
		csFall = !st.cs2 && st.csD;
		locked = st.factLock || st.custLock; // RULE_10
		// Same byte framing in both widths, so enter/exit work in either
		step = qpiMode ? sotp_pkg::STEP_QPI : sotp_pkg::STEP_SPI; // RULE_08
		cntSum = {1'b0, st.cnt} + {1'b0, step};
		byteDone = cntSum[3];
		inByte = qpiMode ? {st.shift[3:0], st.io2} : {st.shift[6:0], st.io2[0]};
		// Lock levels are captured once after reset release
		if (!st.strapDone)
		begin
			next_st.strapDone = 1'b1;
			next_st.factLock = factoryLock; // RULE_10
			next_st.custLock = custLockStored; // RULE_10
		end
		// Reload the read shifter one cycle after the address moved
		if (st.load)
			next_st.outShift = (st.addr > sotp_pkg::OTP_LAST_ADDR) ? sotp_pkg::OTP_BLANK : rdData;
		if (st.cs2)
		begin
			// Deselect: enter, exit and security write execute only on a clean boundary
			if (csRise && st.execOk)
			begin
				case (st.opcode)
					sotp_pkg::OP_ENTER_OTP: next_st.otpMode = 1'b1; // RULE_01
					sotp_pkg::OP_EXIT_OTP: next_st.otpMode = 1'b0; // RULE_02
					sotp_pkg::OP_WRITE_SECURITY:
					begin
						// Lock bit only ever sets
						if (st.shift[sotp_pkg::SEC_CUST_LOCK_BIT])
							next_st.custLock = 1'b1; // RULE_10
					end
					default: next_st.execOk = 1'b0;
				endcase
			end
			next_st.phase = sotp_pkg::SOTP_IDLE;
			next_st.execOk = 1'b0;
		end
		else if (csFall)
		begin
			next_st.phase = sotp_pkg::SOTP_OPCODE;
			next_st.cnt = 3'h0;
			next_st.execOk = 1'b0;
		end
		else if (sckRise && st.phase != sotp_pkg::SOTP_READ)
		begin
			// Any bit past a byte boundary spoils a pending execution
			next_st.execOk = 1'b0;
			next_st.cnt = cntSum[2:0];
			next_st.shift = inByte;
			if (byteDone)
			begin
				case (st.phase)
					sotp_pkg::SOTP_OPCODE:
					begin
						next_st.opcode = inByte;
						next_st.cmdOpcode = inByte;
						next_st.phase = sotp_pkg::SOTP_IGNORE;
						if (st.otpMode && sotp_is_reg_write(inByte))
							next_st.cmdRejected = 1'b1; // RULE_06
						else if (st.otpMode && locked && !sotp_is_read(inByte)
							&& inByte != sotp_pkg::OP_EXIT_OTP && inByte != sotp_pkg::OP_ENTER_OTP)
							next_st.cmdRejected = 1'b1; // RULE_05 RULE_07
						else
						begin
							next_st.cmdStrobe = 1'b1;
							next_st.cmdToOtp = st.otpMode; // RULE_04
							if (inByte == sotp_pkg::OP_ENTER_OTP || inByte == sotp_pkg::OP_EXIT_OTP)
								next_st.execOk = 1'b1; // RULE_01 RULE_02
							// Security write is taken without any write-enable latch check
							else if (inByte == sotp_pkg::OP_WRITE_SECURITY)
								next_st.phase = sotp_pkg::SOTP_SECDATA; // RULE_11
							else if (st.otpMode && (inByte == sotp_pkg::OP_READ_DATA
								|| inByte == sotp_pkg::OP_PAGE_PROGRAM))
							begin
								next_st.phase = sotp_pkg::SOTP_ADDR; // RULE_04
								next_st.addrBytes = 2'h0;
							end
						end
					end
					sotp_pkg::SOTP_ADDR:
					begin
						next_st.addr = {st.addr[15:0], inByte};
						next_st.addrBytes = st.addrBytes + 2'h1;
						if (st.addrBytes == sotp_pkg::ADDR_LAST_BYTE)
						begin
							if (st.opcode == sotp_pkg::OP_PAGE_PROGRAM)
								next_st.phase = sotp_pkg::SOTP_PROG;
							else
							begin
								next_st.phase = sotp_pkg::SOTP_READ;
								next_st.load = 1'b1;
								next_st.fresh = 1'b1;
								next_st.cnt = 3'h0;
							end
						end
					end
					sotp_pkg::SOTP_PROG:
					begin
						// Out-of-range bytes are dropped, never wrapped
						if (!locked && st.addr <= sotp_pkg::OTP_LAST_ADDR)
							next_st.memWe = 1'b1; // RULE_05
						next_st.memAddr = st.addr[sotp_pkg::OTP_ADDR_W-1:0];
						next_st.memData = inByte;
						next_st.addr = st.addr + 24'h00_0001;
					end
					sotp_pkg::SOTP_SECDATA:
					begin
						next_st.execOk = 1'b1;
						next_st.phase = sotp_pkg::SOTP_IGNORE;
					end
					default: next_st.phase = sotp_pkg::SOTP_IGNORE;
				endcase
			end
		end
		else if (sckFall && st.phase == sotp_pkg::SOTP_READ)
		begin
			// First falling edge presents the already loaded MSB
			if (st.fresh)
				next_st.fresh = 1'b0;
			else
			begin
				next_st.outShift = qpiMode ? {st.outShift[3:0], 4'h0} : {st.outShift[6:0], 1'b0};
				next_st.cnt = cntSum[2:0];
				if (byteDone)
				begin
					next_st.addr = st.addr + 24'h00_0001;
					// No skip here: this fall already was the byte's leading edge
					next_st.load = 1'b1;
				end
			end
		end
		if (!nrst)
		begin
			next_st = '0;
			next_st.cs1 = 1'b1;
			next_st.cs2 = 1'b1;
			next_st.csD = 1'b1;
			next_st.otpMode = 1'b0; // RULE_12
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register, synchronous reset folded into next_st
	always_ff @(posedge mclk)
	begin
		st <= next_st;
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs; read data drives io1 in SPI, all four lines in QPI
	assign ioOut = qpiMode ? st.outShift[7:4] : {2'b00, st.outShift[7], 1'b0};
	assign ioOe = (st.phase == sotp_pkg::SOTP_READ && !st.cs2 && !st.load)
		? (qpiMode ? 4'hF : 4'h2) : 4'h0;
	assign otpMode = st.otpMode;
	assign mainWriteBlock = st.otpMode; // RULE_09
	assign customerLock = st.custLock;
	assign cmdStrobe = st.cmdStrobe;
	assign cmdOpcode = st.cmdOpcode;
	assign cmdToOtp = st.cmdToOtp;
	assign cmdRejected = st.cmdRejected;

endmodule : sotp_ctrl

// ===== sotp_pkg.sv
package sotp_pkg;

	// Instruction codes seen on the first byte of a frame
	localparam logic [7:0] OP_ENTER_OTP = 8'hB1;
	localparam logic [7:0] OP_EXIT_OTP = 8'hC1;
	localparam logic [7:0] OP_WRITE_STATUS1 = 8'h01;
	localparam logic [7:0] OP_WRITE_STATUS2 = 8'h31;
	localparam logic [7:0] OP_WRITE_SECURITY = 8'h2F;
	localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
	localparam logic [7:0] OP_READ_DATA = 8'h03;
	localparam logic [7:0] OP_FAST_READ = 8'h0B;
	localparam logic [7:0] OP_DUAL_READ = 8'h3B;
	localparam logic [7:0] OP_QUAD_READ = 8'h6B;
	localparam logic [7:0] OP_QUAD_IO_READ = 8'hEB;
	localparam logic [7:0] OP_READ_STATUS1 = 8'h05;
	localparam logic [7:0] OP_READ_STATUS2 = 8'h35;
	localparam logic [7:0] OP_READ_SECURITY = 8'h2B;

	// Region geometry: 4K bits as 512 bytes
	localparam int OTP_ADDR_W = 9;
	localparam int OTP_BYTES = 512;
	localparam logic [23:0] OTP_LAST_ADDR = 24'h00_01FF;
	localparam logic [7:0] OTP_BLANK = 8'hFF;

	// Security register field holding the customer lock
	localparam int SEC_CUST_LOCK_BIT = 1;

	// Bit steps per serial clock edge and bytes of address
	localparam logic [2:0] STEP_SPI = 3'h1;
	localparam logic [2:0] STEP_QPI = 3'h4;
	localparam logic [1:0] ADDR_LAST_BYTE = 2'h2;

	typedef enum logic [2:0] {
		SOTP_IDLE = 3'b000,
		SOTP_OPCODE = 3'b001,
		SOTP_ADDR = 3'b010,
		SOTP_PROG = 3'b011,
		SOTP_READ = 3'b100,
		SOTP_SECDATA = 3'b101,
		SOTP_IGNORE = 3'b110
	} sotp_phase_t;

endpackage : sotp_pkg

// ===== sotp_array.sv
`timescale 1ns/100ps

module sotp_array
(
	input wire logic mclk,
	input wire logic writeEn,
	input wire logic [sotp_pkg::OTP_ADDR_W-1:0] writeAddr,
	input wire logic [7:0] writeData,
	input wire logic [sotp_pkg::OTP_ADDR_W-1:0] readAddr,
	output logic [7:0] readData
);

	// Storage for the one-time region, apart from the main array
	logic [7:0] mem [0:sotp_pkg::OTP_BYTES-1]; // RULE_03

	////////////////////////////////////////////////////////////////////////
	// Write port; the controller only strobes it for unlocked programs
	always_ff @(posedge mclk)
	begin
		if (writeEn)
		begin
			mem[writeAddr] <= writeData;
		end
	end

	// Asynchronous read keeps the shifter reload to one cycle
	assign readData = mem[readAddr];

endmodule : sotp_array

// ===== sotp_ctrl_props.sv
`timescale 1ns/100ps

module sotp_ctrl_props
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic chipSelN,
	input wire logic qpiMode,
	input wire logic [3:0] ioOe,
	input wire logic otpMode,
	input wire logic mainWriteBlock,
	input wire logic customerLock,
	input wire logic cmdStrobe,
	input wire logic [7:0] cmdOpcode,
	input wire logic cmdToOtp
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	////////////////////////////////////////////////////////////////////////////////
	// Accepted opcode, then the frame closes; mode may only act after the close
	sequence sClosed(logic [7:0] op);
		cmdStrobe && cmdOpcode == op ##[1:20] $rose(chipSelN);
	endsequence
	a_enter_otp: assert property (sClosed(8'hB1) |-> ##[1:8] otpMode)
		else $error("otp mode not entered");
	a_exit_otp: assert property (sClosed(8'hC1) |-> ##[1:8] !otpMode)
		else $error("otp mode not left");
	a_block_main: assert property (mainWriteBlock == otpMode)
		else $error("main write block differs from mode");
	a_lock_sticky: assert property (customerLock |=> customerLock)
		else $error("customer lock cleared");
	a_status_refused: assert property (cmdStrobe && otpMode
		|-> !(cmdOpcode inside {8'h01, 8'h31, 8'h2F})) else $error("register write accepted");
	a_locked_reads: assert property (cmdStrobe && otpMode && customerLock
		|-> cmdOpcode inside {8'h03, 8'h0B, 8'h3B, 8'h6B, 8'hEB, 8'h05, 8'h35, 8'h2B,
		8'hB1, 8'hC1}) else $error("non-read accepted while locked");
	a_route_otp: assert property (cmdStrobe && !(cmdOpcode inside {8'hB1, 8'hC1})
		|-> cmdToOtp == otpMode) else $error("command routed to wrong region");
	a_read_drive: assert property (ioOe != 4'h0
		|-> otpMode && ioOe == (qpiMode ? 4'hF : 4'h2)) else $error("bad output enable");
	a_reset_normal: assert property ($rose(nrst) |-> !otpMode && !customerLock)
		else $error("not in normal mode after reset");
endmodule : sotp_ctrl_props

bind sotp_ctrl sotp_ctrl_props i_sotp_ctrl_props
(
	.mclk(mclk), .nrst(nrst), .chipSelN(chipSelN), .qpiMode(qpiMode), .ioOe(ioOe),
	.otpMode(otpMode), .mainWriteBlock(mainWriteBlock), .customerLock(customerLock),
	.cmdStrobe(cmdStrobe), .cmdOpcode(cmdOpcode), .cmdToOtp(cmdToOtp)
);

// ===== sotp_host.sv
`timescale 1ns/100ps

module sotp_host
(
	output logic serialClk,
	output logic chipSelN,
	output logic [3:0] ioIn,
	input wire logic qpiMode,
	input wire logic [3:0] ioOut
);
	initial
	begin
		serialClk = 1'b0;
		chipSelN = 1'b1;
		ioIn = 4'h0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// One instruction per frame, mode 0; clock stands low outside frames
	task automatic frame(input logic [7:0] tx[$], input int nRd, output logic [7:0] rx[$]);
		int st;
		logic [7:0] sh;
		st = qpiMode ? 4 : 1;
		rx = {};
		#7 chipSelN = 1'b0;
		for (int i = 0; i < tx.size() + nRd; i++)
		begin
			sh = (i < tx.size()) ? tx[i] : 8'h00;
			for (int k = 0; k < 8; k += st)
			begin
				// Released lines toggle so a stale value never looks valid
				if (i < tx.size())
					ioIn = qpiMode ? sh[7:4] : {~ioIn[3:1], sh[7]};
				else
					ioIn = ~ioIn;
				#200 serialClk = 1'b1;
				sh = qpiMode ? {sh[3:0], ioOut} : {sh[6:0], ioOut[1]};
				#200 serialClk = 1'b0;
			end
			if (i >= tx.size())
				rx.push_back(sh);
		end
		// Chip select closes right on the byte boundary
		#100 chipSelN = 1'b1;
		ioIn = ~ioIn;
		#400;
	endtask : frame
endmodule : sotp_host

// ===== sotp_ctrl_tb.sv
`timescale 1ns/100ps

module sotp_ctrl_tb;
	logic mclk, nrst, serialClk, chipSelN, qpiMode, factoryLock, custLockStored;
	logic [3:0] ioIn, ioOut, ioOe;
	logic otpMode, mainWriteBlock, customerLock, cmdStrobe, cmdToOtp, cmdRejected;
	logic [7:0] cmdOpcode, d0, d1;
	logic [8:0] a;
	logic [7:0] rx[$];
	logic [7:0] ops[6] = '{8'h01, 8'h31, 8'h2F, 8'h02, 8'h20, 8'h0B};
	int n_mismatch = 0;
	int checks = 0;
	int seed = 84957;
	int nStb = 0;
	int nRej = 0;
	int cycles = 0;

	sotp_ctrl i_sotp_ctrl (.mclk(mclk), .nrst(nrst), .serialClk(serialClk),
		.chipSelN(chipSelN), .ioIn(ioIn), .qpiMode(qpiMode), .factoryLock(factoryLock),
		.custLockStored(custLockStored), .ioOut(ioOut), .ioOe(ioOe), .otpMode(otpMode),
		.mainWriteBlock(mainWriteBlock), .customerLock(customerLock), .cmdStrobe(cmdStrobe),
		.cmdOpcode(cmdOpcode), .cmdToOtp(cmdToOtp), .cmdRejected(cmdRejected));
	sotp_host i_sotp_host (.serialClk(serialClk), .chipSelN(chipSelN), .ioIn(ioIn),
		.qpiMode(qpiMode), .ioOut(ioOut));

	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Pulses last one cycle, so they are tallied and judged after each frame
	always @(posedge mclk)
	begin
		nStb <= nStb + int'(cmdStrobe === 1'b1);
		nRej <= nRej + int'(cmdRejected === 1'b1);
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			n_mismatch++;
			results();
		end
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Refusal expected for one opcode, given mode and lock
	function automatic logic expRej(input logic [7:0] op, input logic otp, input logic lock);
		logic rd;
		rd = op inside {8'h03, 8'h0B, 8'h3B, 8'h6B, 8'hEB, 8'h05, 8'h35, 8'h2B};
		return otp && (op inside {8'h01, 8'h31, 8'h2F} || (lock && !rd));
	endfunction : expRej

	task automatic send(input logic [7:0] tx[$], input int nRd);
		@(posedge mclk);
		i_sotp_host.frame(tx, nRd, rx);
		@(posedge mclk);
	endtask : send

	task automatic try(input logic [7:0] op, input logic otp, input logic lock);
		int s0;
		int r0;
		logic e;
		s0 = nStb;
		r0 = nRej;
		e = expRej(op, otp, lock);
		send({op}, 0);
		chk(nRej - r0, e);
		chk(nStb - s0, !e);
		chk(cmdOpcode, op);
		if (!e)
			chk(cmdToOtp, otp);
	endtask : try

	task automatic rst(input logic fac, input logic cust);
		nrst <= 1'b0;
		factoryLock <= fac;
		custLockStored <= cust;
		repeat (5) @(posedge mclk);
		nrst <= 1'b1;
		repeat (5) @(posedge mclk);
	endtask : rst

	task automatic results;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : results
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		nrst = 1'b0;
		qpiMode = 1'b0;
		factoryLock = 1'b0;
		custLockStored = 1'b0;
		rst(1'b0, 1'b0);
		chk({otpMode, mainWriteBlock, customerLock}, 8'h00);
		try(8'h03, 1'b0, 1'b0);
		// Enter, program, read back and refuse, in both line widths
		for (int q = 0; q < 2; q++)
		begin
			qpiMode <= q[0];
			send({8'hB1}, 0);
			chk({otpMode, mainWriteBlock}, 8'h03);
			a = 9'($unsigned($random(seed)) % 510);
			d0 = 8'($random(seed));
			d1 = 8'($random(seed));
			send({8'h02, 8'h00, {7'h00, a[8]}, a[7:0], d0, d1}, 0);
			send({8'h03, 8'h00, {7'h00, a[8]}, a[7:0]}, 2);
			chk(rx[0], d0);
			chk(rx[1], d1);
			send({8'h03, 8'h00, 8'h02, 8'h00}, 1);
			chk(rx[0], 8'hFF);
			foreach (ops[j])
				try(ops[j], 1'b1, 1'b0);
			send({8'hC1}, 0);
			chk({otpMode, mainWriteBlock}, 8'h00);
			$display("test width %0d done", q);
		end
		// Lock through the security register, no write enable first
		qpiMode <= 1'b0;
		send({8'h2F, 8'h02}, 0);
		chk(customerLock, 1'b1);
		send({8'hB1}, 0);
		send({8'h02, 8'h00, {7'h00, a[8]}, a[7:0], ~d0}, 0);
		send({8'h03, 8'h00, {7'h00, a[8]}, a[7:0]}, 1);
		chk(rx[0], d0);
		foreach (ops[j])
			try(ops[j], 1'b1, 1'b1);
		send({8'hC1}, 0);
		$display("test customer lock done");
		// Locks survive reset through the stored and factory levels
		rst(1'b0, 1'b1);
		chk(customerLock, 1'b1);
		rst(1'b1, 1'b0);
		send({8'hB1}, 0);
		try(8'h02, 1'b1, 1'b1);
		$display("test stored locks done");
		results();
	end
endmodule : sotp_ctrl_tb
